/* File: hdl/exec_params.svh */
// Constants for the flag, shift, bit-transfer, copy and indirect load slice.
// Functional notes
// - Branch when interrupts on: PC+k+1, 1/2 cycles.
// - Branch when interrupts off: PC+k+1, 1/2 cycles.
// - I/O bit raise/drop, two cycles, flags kept.
// - Left shift/rotate, carry from bit 7.
// - Right shift/rotate, carry from bit 0.
// - Arithmetic right shift keeps bit 7.
// - Global interrupt on/off touches only I.
// - Overflow set/clear touches only V.
// - Half carry set/clear touches only H.
// - S, C, N, Z, T set/clear individually.
// - Capture register bit into T flag.
// - Deposit T flag into register bit.
// - Register and pair copy, one cycle, no flags.
// - Post-increment load: read, then pointer plus one.
// - Pre-decrement load: pointer minus one, then read.
// - Displacement load: pointer plus q, pointer kept.
`ifndef EXEC_PARAMS_SVH
`define EXEC_PARAMS_SVH
`define OFF_OP 8'h00
`define OFF_STATUS 8'h04
`define OFF_PC 8'h08
`define OFF_SEL 8'h0c
`define OFF_RF 8'h10
`define OFF_IO 8'h14
`define OFF_MEM 8'h18
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define FLAG_C 0
`define FLAG_Z 1
`define FLAG_N 2
`define FLAG_V 3
`define FLAG_H 5
`define FLAG_T 6
`define FLAG_I 7
`define STATUS_FLAGS_REGISTER_RST 8'h00
`define PC_RST 16'h0000
`define PTR_X 5'h1a
`define PTR_Y 5'h1c
`define PTR_Z 5'h1e
`define IW_OP 4:0
`define IW_RD 9:5
`define IW_RR 14:10
`define IW_BIT 17:15
`define IW_PTR 19:18
`define IW_IMM 31:24
`define SEL_RF 4:0
`define SEL_IO 12:8
`define SEL_MEM_LSB 16
`define IO_REGS 32
`endif

/* File: hdl/exec_pkg.sv */
// Types shared by the execution slice.
package exec_pkg;
  typedef enum logic [4:0] {
    OP_NOP = 5'h00, OP_BR_ION = 5'h01, OP_BR_IOFF = 5'h02, OP_IO_RAISE = 5'h03,
    OP_IO_DROP = 5'h04, OP_LSL = 5'h05, OP_LSR = 5'h06, OP_ROL = 5'h07,
    OP_ROR = 5'h08, OP_ASR = 5'h09, OP_SBIT_RAISE = 5'h0a, OP_SBIT_LOWER = 5'h0b,
    OP_TCAP = 5'h0c, OP_TDEP = 5'h0d, OP_COPY = 5'h0e, OP_PAIR_COPY = 5'h0f,
    OP_IMM_LOAD = 5'h10, OP_LD_PLAIN = 5'h11, OP_LD_POSTINC = 5'h12,
    OP_LD_PREDEC = 5'h13, OP_LD_DISP = 5'h14
  } op_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_EXEC = 2'b01, ST_SECOND = 2'b10
  } state_t;
endpackage : exec_pkg

/* File: hdl/shift_flag_unit.sv */
// Shift and rotate datapath with its flag update.
`timescale 1ns/1ps
`include "exec_params.svh"
module shift_flag_unit (
  // Operation and operand
  input wire exec_pkg::op_t op,
  input wire logic [7:0] operand,
  input wire logic [7:0] flags_in,
  // Result
  output logic [7:0] result,
  output logic [7:0] flags_out
);
  import exec_pkg::*;
  logic carry;
  always_comb begin
    result = operand;
    carry = flags_in[`FLAG_C];
    case (op)
      OP_LSL: begin
        result = {operand[6:0], 1'b0};
        carry = operand[7];
      end
      OP_ROL: begin
        result = {operand[6:0], flags_in[`FLAG_C]};
        carry = operand[7];
      end
      OP_LSR: begin
        result = {1'b0, operand[7:1]};
        carry = operand[0];
      end
      OP_ROR: begin
        result = {flags_in[`FLAG_C], operand[7:1]};
        carry = operand[0];
      end
      OP_ASR: begin
        result = {operand[7], operand[7:1]};
        carry = operand[0];
      end
      default: begin
        result = operand;
      end
    endcase
    flags_out = flags_in;
    flags_out[`FLAG_C] = carry;
    flags_out[`FLAG_Z] = (result == 8'h00);
    flags_out[`FLAG_N] = result[7];
    flags_out[`FLAG_V] = result[7] ^ carry;
  end
endmodule : shift_flag_unit

/* File: hdl/cpu_bitops_flags_loads.sv */
// Execution slice with register file, I/O bits, data memory and AXI4-Lite access.
//
// Added by the designer: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`include "exec_params.svh"
module cpu_bitops_flags_loads #(
  parameter int DMEM_DEPTH = 256
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write address and data
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // Write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // Read address and data
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  import exec_pkg::*;
  localparam int AW = $clog2(DMEM_DEPTH);

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        merge[8*i +: 8] = nw[8*i +: 8];
      end
    end
  endfunction : merge

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == `OFF_OP) || (a == `OFF_STATUS) || (a == `OFF_PC) || (a == `OFF_SEL) ||
             (a == `OFF_RF) || (a == `OFF_IO) || (a == `OFF_MEM);
  endfunction : mapped

  state_t st_q, st_d;
  logic [31:0] instr_q, instr_d, sel_q, sel_d;
  logic [15:0] pc_q, pc_d, addr_q, addr_d, koff, ptr_val;
  logic [7:0] status_flags_register_q, status_flags_register_d, imm, rf_rd, sh_res, sh_flags;
  logic [7:0] rf_q [32];
  logic [7:0] rf_d [32];
  logic [7:0] io_q [`IO_REGS];
  logic [7:0] io_d [`IO_REGS];
  logic [7:0] dmem_q [DMEM_DEPTH];
  logic [4:0] rd, rr, pidx, pidx_hi;
  logic [2:0] bsel;
  logic [AW-1:0] sel_ma;
  logic mem_we;
  op_t op;

  logic aw_got_q, aw_got_d, w_got_q, w_got_d, bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [7:0] waddr_q, waddr_d;
  logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d, rd_word;
  logic [3:0] wstrb_q, wstrb_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic wr_fire, wr_ok, busy;

  assign op = op_t'(instr_q[`IW_OP]);
  assign rd = instr_q[`IW_RD];
  assign rr = instr_q[`IW_RR];
  assign bsel = instr_q[`IW_BIT];
  assign imm = instr_q[`IW_IMM];
  assign koff = {{9{imm[6]}}, imm[6:0]};
  assign rf_rd = rf_q[rd];
  assign pidx = (instr_q[`IW_PTR] == 2'h0) ? `PTR_X : (instr_q[`IW_PTR] == 2'h1) ? `PTR_Y : `PTR_Z;
  assign pidx_hi = {pidx[4:1], 1'b1};
  assign ptr_val = {rf_q[pidx_hi], rf_q[pidx]};
  assign sel_ma = sel_q[`SEL_MEM_LSB +: AW];
  assign busy = (st_q != ST_IDLE);

  shift_flag_unit u_shift (
    .op(op),
    .operand(rf_rd),
    .flags_in(status_flags_register_q),
    .result(sh_res),
    .flags_out(sh_flags)
  );

  assign awready = !aw_got_q && !bvalid_q;
  assign wready = !w_got_q && !bvalid_q;
  assign arready = !rvalid_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign wr_fire = aw_got_q && w_got_q;
  assign wr_ok = wr_fire && !busy && mapped(waddr_q);

  always_comb begin
    rd_word = 32'h0000_0000;
    case (araddr)
      `OFF_OP: rd_word = instr_q;
      `OFF_STATUS: rd_word = {23'h00_0000, busy, status_flags_register_q};
      `OFF_PC: rd_word = {16'h0000, pc_q};
      `OFF_SEL: rd_word = sel_q;
      `OFF_RF: rd_word = {24'h00_0000, rf_q[sel_q[`SEL_RF]]};
      `OFF_IO: rd_word = {24'h00_0000, io_q[sel_q[`SEL_IO]]};
      `OFF_MEM: rd_word = {24'h00_0000, dmem_q[sel_ma]};
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always_comb begin
    aw_got_d = aw_got_q;
    w_got_d = w_got_q;
    waddr_d = waddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (awvalid && awready) begin
      aw_got_d = 1'b1;
      waddr_d = awaddr;
    end
    if (wvalid && wready) begin
      w_got_d = 1'b1;
      wdata_d = wdata;
      wstrb_d = wstrb;
    end
    if (wr_fire) begin
      aw_got_d = 1'b0;
      w_got_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = wr_ok ? `RESP_OKAY : `RESP_SLVERR;
    end else if (bvalid_q && bready) begin
      bvalid_d = 1'b0;
    end
    if (arvalid && arready) begin
      rvalid_d = 1'b1;
      rdata_d = rd_word;
      rresp_d = mapped(araddr) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rvalid_q && rready) begin
      rvalid_d = 1'b0;
    end
  end

  always_comb begin
    st_d = st_q;
    instr_d = instr_q;
    pc_d = pc_q;
    status_flags_register_d = status_flags_register_q;
    sel_d = sel_q;
    addr_d = addr_q;
    rf_d = rf_q;
    io_d = io_q;
    mem_we = 1'b0;
    unique case (st_q)
      ST_IDLE: begin
        if (wr_ok) begin
          case (waddr_q)
            `OFF_OP: begin
              instr_d = merge(32'h0000_0000, wdata_q, wstrb_q);
              st_d = ST_EXEC;
            end
            `OFF_STATUS: if (wstrb_q[0]) status_flags_register_d = wdata_q[7:0];
            `OFF_SEL: sel_d = merge(sel_q, wdata_q, wstrb_q);
            `OFF_RF: if (wstrb_q[0]) rf_d[sel_q[`SEL_RF]] = wdata_q[7:0];
            `OFF_IO: if (wstrb_q[0]) io_d[sel_q[`SEL_IO]] = wdata_q[7:0];
            `OFF_MEM: mem_we = wstrb_q[0];
            default: mem_we = 1'b0;
          endcase
        end
      end
      ST_EXEC: begin
        pc_d = pc_q + 16'h0001;
        st_d = ST_IDLE;
        case (op)
          OP_BR_ION: if (status_flags_register_q[`FLAG_I]) begin
            pc_d = pc_q + koff + 16'h0001;
            st_d = ST_SECOND;
          end
          OP_BR_IOFF: if (!status_flags_register_q[`FLAG_I]) begin
            pc_d = pc_q + koff + 16'h0001;
            st_d = ST_SECOND;
          end
          OP_IO_RAISE, OP_IO_DROP: begin
            io_d[imm[4:0]][bsel] = (op == OP_IO_RAISE);
            st_d = ST_SECOND;
          end
          OP_LSL, OP_LSR, OP_ROL, OP_ROR, OP_ASR: begin
            rf_d[rd] = sh_res;
            status_flags_register_d = sh_flags;
          end
          OP_SBIT_RAISE: status_flags_register_d[bsel] = 1'b1;
          OP_SBIT_LOWER: status_flags_register_d[bsel] = 1'b0;
          OP_TCAP: status_flags_register_d[`FLAG_T] = rf_rd[bsel];
          OP_TDEP: rf_d[rd][bsel] = status_flags_register_q[`FLAG_T];
          OP_COPY: rf_d[rd] = rf_q[rr];
          OP_PAIR_COPY: begin
            rf_d[{rd[4:1], 1'b0}] = rf_q[{rr[4:1], 1'b0}];
            rf_d[{rd[4:1], 1'b1}] = rf_q[{rr[4:1], 1'b1}];
          end
          OP_IMM_LOAD: rf_d[rd] = imm;
          OP_LD_PLAIN, OP_LD_POSTINC: begin
            addr_d = ptr_val;
            st_d = ST_SECOND;
          end
          OP_LD_PREDEC: begin
            addr_d = ptr_val - 16'h0001;
            rf_d[pidx] = addr_d[7:0];
            rf_d[pidx_hi] = addr_d[15:8];
            st_d = ST_SECOND;
          end
          OP_LD_DISP: begin
            addr_d = ptr_val + {10'h000, imm[5:0]};
            st_d = ST_SECOND;
          end
          default: st_d = ST_IDLE;
        endcase
      end
      ST_SECOND: begin
        st_d = ST_IDLE;
        if (op == OP_LD_PLAIN || op == OP_LD_POSTINC || op == OP_LD_PREDEC || op == OP_LD_DISP) begin
          rf_d[rd] = dmem_q[addr_q[AW-1:0]];
        end
        if (op == OP_LD_POSTINC) begin
          rf_d[pidx] = 8'(addr_q + 16'h0001);
          rf_d[pidx_hi] = 8'((addr_q + 16'h0001) >> 8);
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (mem_we) begin
      dmem_q[sel_ma] <= wdata_q[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= ST_IDLE;
      instr_q <= 32'h0000_0000;
      pc_q <= `PC_RST;
      status_flags_register_q <= `STATUS_FLAGS_REGISTER_RST;
      sel_q <= 32'h0000_0000;
      addr_q <= 16'h0000;
      rf_q <= '{default: 8'h00};
      io_q <= '{default: 8'h00};
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      waddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `RESP_OKAY;
    end else begin
      st_q <= st_d;
      instr_q <= instr_d;
      pc_q <= pc_d;
      status_flags_register_q <= status_flags_register_d;
      sel_q <= sel_d;
      addr_q <= addr_d;
      rf_q <= rf_d;
      io_q <= io_d;
      aw_got_q <= aw_got_d;
      w_got_q <= w_got_d;
      waddr_q <= waddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence two_cycle_end;
    st_q == ST_SECOND ##1 st_q == ST_IDLE;
  endsequence

  br_on_taken_a: assert property (st_q == ST_EXEC && op == OP_BR_ION && status_flags_register_q[`FLAG_I] |=>
    pc_q == $past(pc_q) + $past(koff) + 16'h0001 && status_flags_register_q == $past(status_flags_register_q) ##0 two_cycle_end)
    else $error("Taken branch on interrupts on went wrong.");
  br_off_skip_a: assert property (st_q == ST_EXEC && op == OP_BR_IOFF && status_flags_register_q[`FLAG_I] |=>
    st_q == ST_IDLE && pc_q == $past(pc_q) + 16'h0001)
    else $error("Untaken branch on interrupts off went wrong.");
  io_bit_a: assert property (st_q == ST_EXEC && op == OP_IO_RAISE |=>
    io_q[$past(imm[4:0])][$past(bsel)] && status_flags_register_q == $past(status_flags_register_q) ##0 two_cycle_end)
    else $error("I/O bit raise went wrong.");
  rotate_left_a: assert property (st_q == ST_EXEC && op == OP_ROL |=> st_q == ST_IDLE &&
    rf_q[$past(rd)] == {$past(rf_rd[6:0]), $past(status_flags_register_q[`FLAG_C])} && status_flags_register_q[`FLAG_C] == $past(rf_rd[7]))
    else $error("Rotate left went wrong.");
  rotate_right_a: assert property (st_q == ST_EXEC && op == OP_ROR |=>
    rf_q[$past(rd)] == {$past(status_flags_register_q[`FLAG_C]), $past(rf_rd[7:1])} && status_flags_register_q[`FLAG_C] == $past(rf_rd[0]))
    else $error("Rotate right went wrong.");
  arith_shift_a: assert property (st_q == ST_EXEC && op == OP_ASR |=>
    rf_q[$past(rd)] == {$past(rf_rd[7]), $past(rf_rd[7:1])} && status_flags_register_q[`FLAG_Z] == (rf_q[$past(rd)] == 8'h00))
    else $error("Arithmetic shift right went wrong.");
  irq_flag_a: assert property (st_q == ST_EXEC && op == OP_SBIT_RAISE && bsel == 3'h7 |=>
    st_q == ST_IDLE && status_flags_register_q == ($past(status_flags_register_q) | 8'h80))
    else $error("Global interrupt on went wrong.");
  flag_clear_a: assert property (st_q == ST_EXEC && op == OP_SBIT_LOWER |=>
    status_flags_register_q == ($past(status_flags_register_q) & ~(8'h01 << $past(bsel))))
    else $error("Single flag clear went wrong.");
  t_capture_a: assert property (st_q == ST_EXEC && op == OP_TCAP |=>
    status_flags_register_q == {$past(status_flags_register_q[7]), $past(rf_rd[bsel]), $past(status_flags_register_q[5:0])} && status_flags_register_q[7] == $past(status_flags_register_q[7]))
    else $error("T capture went wrong.");
  t_deposit_a: assert property (st_q == ST_EXEC && op == OP_TDEP |=>
    rf_q[$past(rd)][$past(bsel)] == status_flags_register_q[`FLAG_T] && status_flags_register_q == $past(status_flags_register_q))
    else $error("T deposit went wrong.");
  reg_copy_a: assert property (st_q == ST_EXEC && op == OP_COPY |=>
    rf_q[$past(rd)] == $past(rf_q[rr]) && status_flags_register_q == $past(status_flags_register_q) && st_q == ST_IDLE)
    else $error("Register copy went wrong.");
  load_postinc_a: assert property (st_q == ST_EXEC && op == OP_LD_POSTINC |=> two_cycle_end ##0
    ptr_val == $past(ptr_val, 2) + 16'h0001 && status_flags_register_q == $past(status_flags_register_q, 2))
    else $error("Post-increment load went wrong.");
  load_predec_a: assert property (st_q == ST_EXEC && op == OP_LD_PREDEC |=>
    addr_q == $past(ptr_val) - 16'h0001 ##0 two_cycle_end)
    else $error("Pre-decrement load went wrong.");
  load_disp_a: assert property (st_q == ST_EXEC && op == OP_LD_DISP && rd[4:1] != pidx[4:1] |=>
    two_cycle_end ##0 ptr_val == $past(ptr_val, 2) && rf_q[rd] == dmem_q[$past(addr_q[AW-1:0])])
    else $error("Displacement load went wrong.");
endmodule : cpu_bitops_flags_loads

/* File: dv/axil_host.sv */
// Bus master model that issues single AXI4-Lite transfers.
`timescale 1ns/1ps
module axil_host (
  // Clock
  input wire logic aclk,
  // Write channels
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  // Read channels
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end
  // Released addresses and write data show the inverse so stale values are never mistaken for live ones; wstrb stays 4'hf.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ad;
    logic wd;
    ad = 1'h0;
    wd = 1'h0;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'h1;
    wdata <= d;
    wstrb <= 4'hf;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (!ad && awready === 1'h1) begin
        ad = 1'h1;
        awvalid <= 1'h0;
        awaddr <= ~a;
      end
      if (!wd && wready === 1'h1) begin
        wd = 1'h1;
        wvalid <= 1'h0;
        wdata <= ~d;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'h1);
    r = bresp;
    bready <= 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge aclk); while (arready !== 1'h1);
    arvalid <= 1'h0;
    araddr <= ~a;
    do @(posedge aclk); while (rvalid !== 1'h1);
    d = rdata;
    r = rresp;
    rready <= 1'h0;
  endtask : rd
endmodule : axil_host

/* File: dv/tb_cpu_bitops_flags_loads.sv */
// Self-checking bench for the execution slice.
`timescale 1ns/1ps
`include "exec_params.svh"
module tb_cpu_bitops_flags_loads;
  import exec_pkg::*;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  int error_cnt = 0;
  int checks_done = 0;
  cpu_bitops_flags_loads #(.DMEM_DEPTH(256)) DUT (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready));
  axil_host host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
  initial begin
    aclk = 1'h0;
    forever #5 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic bw(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    host.wr(a, d, r);
    chk({30'h0, r}, {30'h0, `RESP_OKAY});
  endtask : bw
  task automatic br(input logic [7:0] a, output logic [31:0] d);
    logic [1:0] r;
    host.rd(a, d, r);
    chk({30'h0, r}, {30'h0, `RESP_OKAY});
  endtask : br
  // Launches one instruction and waits until the core is idle again.
  task automatic x(input op_t o, input logic [4:0] d, input logic [4:0] s, input logic [2:0] b,
                   input logic [1:0] p, input logic [7:0] k);
    logic [31:0] v;
    bw(`OFF_OP, {k, 4'h0, p, b, s, d, o});
    do br(`OFF_STATUS, v); while (v[8] !== 1'h0);
  endtask : x
  task automatic setr(input logic [4:0] i, input logic [7:0] v);
    bw(`OFF_SEL, {27'h0, i});
    bw(`OFF_RF, {24'h0, v});
  endtask : setr
  task automatic chkr(input logic [4:0] i, input logic [7:0] v);
    logic [31:0] d;
    bw(`OFF_SEL, {27'h0, i});
    br(`OFF_RF, d);
    chk(d, {24'h0, v});
  endtask : chkr
  task automatic chks(input logic [7:0] v);
    logic [31:0] d;
    br(`OFF_STATUS, d);
    chk(d, {24'h0, v});
  endtask : chks
  task automatic t_shift();
    op_t ops[5];
    logic [7:0] v;
    logic [7:0] r;
    logic c;
    ops = '{OP_LSL, OP_LSR, OP_ROL, OP_ROR, OP_ASR};
    for (int j = 0; j < 10; j++) begin
      v = (j < 5) ? 8'h81 : 8'h01;
      setr(5'h03, v);
      bw(`OFF_STATUS, 32'h0000_00f1);
      x(ops[j % 5], 5'h03, 5'h03, 3'h0, 2'h0, 8'h00);
      case (ops[j % 5])
        OP_LSL: {c, r} = {v, 1'h0};
        OP_LSR: {r, c} = {1'h0, v};
        OP_ROL: {c, r} = {v, 1'h1};
        OP_ROR: {r, c} = {1'h1, v};
        default: {r, c} = {v[7], v};
      endcase
      chkr(5'h03, r);
      chks({4'hf, r[7] ^ c, r[7], r == 8'h00, c});
    end
    $display("shift test done");
  endtask : t_shift
  task automatic t_flags();
    for (int s = 0; s < 8; s++) begin
      bw(`OFF_STATUS, 32'h0000_0000);
      x(OP_SBIT_RAISE, 5'h00, 5'h00, s[2:0], 2'h0, 8'h00);
      chks(8'h01 << s);
      bw(`OFF_STATUS, 32'h0000_00ff);
      x(OP_SBIT_LOWER, 5'h00, 5'h00, s[2:0], 2'h0, 8'h00);
      chks(~(8'h01 << s));
    end
    $display("flag test done");
  endtask : t_flags
  task automatic t_branch();
    logic [31:0] p0;
    logic [31:0] p1;
    logic [7:0] k;
    logic [15:0] e;
    for (int j = 0; j < 4; j++) begin
      k = j[0] ? 8'h7e : 8'h05;
      bw(`OFF_STATUS, j[0] ? 32'h0000_0080 : 32'h0000_0000);
      br(`OFF_PC, p0);
      x(j[1] ? OP_BR_IOFF : OP_BR_ION, 5'h00, 5'h00, 3'h0, 2'h0, k);
      e = p0[15:0] + 16'h0001 + ((j[0] ^ j[1]) ? {{9{k[6]}}, k[6:0]} : 16'h0000);
      br(`OFF_PC, p1);
      chk(p1, {16'h0000, e});
      chks(j[0] ? 8'h80 : 8'h00);
    end
    $display("branch test done");
  endtask : t_branch
  task automatic t_io();
    logic [31:0] d;
    bw(`OFF_SEL, 32'h0000_0500);
    bw(`OFF_IO, 32'h0000_005a);
    bw(`OFF_STATUS, 32'h0000_00a5);
    x(OP_IO_RAISE, 5'h00, 5'h00, 3'h0, 2'h0, 8'h05);
    br(`OFF_IO, d);
    chk(d, 32'h0000_005b);
    x(OP_IO_DROP, 5'h00, 5'h00, 3'h6, 2'h0, 8'h05);
    br(`OFF_IO, d);
    chk(d, 32'h0000_001b);
    chks(8'ha5);
    $display("io test done");
  endtask : t_io
  task automatic t_tbit();
    bw(`OFF_STATUS, 32'h0000_0080);
    setr(5'h03, 8'h10);
    x(OP_TCAP, 5'h03, 5'h03, 3'h4, 2'h0, 8'h00);
    chks(8'hc0);
    setr(5'h04, 8'h00);
    x(OP_TDEP, 5'h04, 5'h04, 3'h7, 2'h0, 8'h00);
    chkr(5'h04, 8'h80);
    chks(8'hc0);
    x(OP_TCAP, 5'h03, 5'h03, 3'h0, 2'h0, 8'h00);
    chks(8'h80);
    $display("bit transfer test done");
  endtask : t_tbit
  task automatic t_copy();
    bw(`OFF_STATUS, 32'h0000_005a);
    setr(5'h00, 8'h11);
    setr(5'h01, 8'h3c);
    x(OP_COPY, 5'h02, 5'h01, 3'h0, 2'h0, 8'h00);
    chkr(5'h02, 8'h3c);
    x(OP_PAIR_COPY, 5'h04, 5'h00, 3'h0, 2'h0, 8'h00);
    chkr(5'h04, 8'h11);
    chkr(5'h05, 8'h3c);
    chks(8'h5a);
    $display("copy test done");
  endtask : t_copy
  task automatic t_load();
    bw(`OFF_SEL, 32'h00ff_0000);
    bw(`OFF_MEM, 32'h0000_005e);
    bw(`OFF_SEL, 32'h0015_0000);
    bw(`OFF_MEM, 32'h0000_0077);
    setr(5'h1a, 8'hff);
    setr(5'h1b, 8'h00);
    bw(`OFF_STATUS, 32'h0000_003c);
    x(OP_LD_POSTINC, 5'h00, 5'h00, 3'h0, 2'h0, 8'h00);
    chkr(5'h00, 8'h5e);
    chkr(5'h1a, 8'h00);
    chkr(5'h1b, 8'h01);
    x(OP_LD_PREDEC, 5'h01, 5'h00, 3'h0, 2'h0, 8'h00);
    chkr(5'h01, 8'h5e);
    chkr(5'h1a, 8'hff);
    chkr(5'h1b, 8'h00);
    setr(5'h1c, 8'h10);
    setr(5'h1d, 8'h00);
    x(OP_LD_DISP, 5'h02, 5'h00, 3'h0, 2'h1, 8'h05);
    chkr(5'h02, 8'h77);
    chkr(5'h1c, 8'h10);
    x(OP_LD_PLAIN, 5'h03, 5'h00, 3'h0, 2'h0, 8'h00);
    chkr(5'h03, 8'h5e);
    chkr(5'h1a, 8'hff);
    x(OP_IMM_LOAD, 5'h06, 5'h00, 3'h0, 2'h0, 8'ha7);
    chkr(5'h06, 8'ha7);
    chks(8'h3c);
    $display("load test done");
  endtask : t_load
  task automatic t_bus();
    logic [31:0] d;
    logic [1:0] r;
    chks(8'h00);
    host.wr(8'h1c, 32'h0000_0001, r);
    chk({30'h0, r}, {30'h0, `RESP_SLVERR});
    host.rd(8'h1c, d, r);
    chk({d, r}, {32'h0000_0000, `RESP_SLVERR});
    $display("bus test done");
  endtask : t_bus
  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test
  initial begin
    repeat (30000) @(posedge aclk);
    error_cnt++;
    $display("[FAIL] %0t watchdog expired", $time);
    stop_test();
  end
  initial begin
    aresetn = 1'h0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    t_bus();
    t_shift();
    t_flags();
    t_branch();
    t_io();
    t_tbit();
    t_copy();
    t_load();
    stop_test();
  end
endmodule : tb_cpu_bitops_flags_loads
